// file: verilog/sccs_pkg.sv
// constants and types for the sync code framer and dark-level fault flags
package sccs_pkg;

  // bus and word widths, channel and group counts
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CODE_W = 10;
  localparam int unsigned LOW_W  = 7;
  localparam int unsigned CHAN_N = 64;
  localparam int unsigned GRP_W  = 16;
  localparam int unsigned GRP_N  = 4;
  localparam int unsigned STAT_W = 3;

  typedef logic [ADDR_W-1:0] sccs_addr_t;
  typedef logic [DATA_W-1:0] sccs_word_t;
  typedef logic [CODE_W-1:0] sccs_code_t;
  typedef logic [LOW_W-1:0]  sccs_low_t;
  typedef logic [STAT_W-1:0] sccs_stat_t;

  // register addresses
  localparam sccs_addr_t A_TRAIN_WORD = 8'h82;
  localparam sccs_addr_t A_FRAME_LOW  = 8'h83;
  localparam sccs_addr_t A_DARK_CODE  = 8'h84;
  localparam sccs_addr_t A_VALID_CODE = 8'h85;
  localparam sccs_addr_t A_CRC_CODE   = 8'h86;
  localparam sccs_addr_t A_TRAIN_CODE = 8'h87;
  localparam sccs_addr_t A_FAULT0     = 8'h88;
  localparam sccs_addr_t A_FAULT1     = 8'h89;
  localparam sccs_addr_t A_FAULT2     = 8'h8a;
  localparam sccs_addr_t A_FAULT3     = 8'h8b;
  localparam sccs_addr_t A_SPARE0     = 8'h8c;
  localparam sccs_addr_t A_SPARE1     = 8'h8d;
  localparam sccs_addr_t A_IRQ_STAT   = 8'h8e;
  localparam sccs_addr_t A_IRQ_MASK   = 8'h8f;
  localparam sccs_addr_t A_LINK_STATE = 8'h90;

  // reset values
  localparam sccs_low_t  RST_FRAME_LOW  = 7'h2a;
  localparam sccs_code_t RST_DARK_CODE  = 10'h015;
  localparam sccs_code_t RST_VALID_CODE = 10'h035;
  localparam sccs_code_t RST_CRC_CODE   = 10'h059;
  localparam sccs_code_t RST_TRAIN_WORD = 10'h3a6;
  localparam sccs_code_t RST_TRAIN_CODE = RST_TRAIN_WORD;
  localparam sccs_word_t RST_SPARE0     = 16'h0000;
  localparam sccs_word_t RST_SPARE1     = 16'hffff;
  localparam sccs_stat_t RST_STAT       = 3'h0;

  // marker bit positions
  localparam int unsigned MK_FRAME_BIT = 9;
  localparam int unsigned MK_START_BIT = 8;
  localparam int unsigned MK_END_BIT   = 7;

  // interrupt status bit positions
  localparam int unsigned ST_FAULT  = 0;
  localparam int unsigned ST_FSTART = 1;
  localparam int unsigned ST_FEND   = 2;

  // word kinds offered on the request port
  typedef enum logic [2:0] {
    K_IDLE  = 3'h0,
    K_FS    = 3'h1,
    K_FE    = 3'h2,
    K_LS    = 3'h3,
    K_LE    = 3'h4,
    K_DARK  = 3'h5,
    K_VALID = 3'h6,
    K_CRC   = 3'h7
  } sccs_kind_t;

  // position in the stream
  typedef enum logic [1:0] {
    FS_IDLE  = 2'h0,
    FS_FRAME = 2'h1,
    FS_LINE  = 2'h3
  } sccs_fstate_t;

endpackage : sccs_pkg

// file: verilog/sccs_fault_word.sv
// one group of per-channel dark-level calibration fault flags
`timescale 1ns/100ps
module sccs_fault_word #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // calibration result
  input  wire logic         update,
  input  wire logic [W-1:0] short_in,
  // flags
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_r;

  // each calibration run replaces the previous verdict
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else if (update) begin
      flags_r <= short_in;
    end
  end

  assign flags = flags_r;

endmodule : sccs_fault_word

// file: verilog/sccs_framer.sv
// sync code framer with dark-level calibration fault register bank
// Function
// - frame marker: seven writable low bits, 0x2a
// - top bits: frame/line, start, end
// - dark pixel marker code, writable, 0x015
// - valid pixel marker code, writable, 0x035
// - checksum marker code, writable, 0x059
// - flag channel when dark samples too few
// - 64 read-only fault bits, four ascending words
// - idle data channel carries training word
`timescale 1ns/100ps
module sccs_framer (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // register port
  input  wire sccs_pkg::sccs_addr_t reg_addr,
  input  wire sccs_pkg::sccs_word_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output sccs_pkg::sccs_word_t      reg_rdata,
  // word request
  input  wire sccs_pkg::sccs_kind_t word_kind,
  input  wire sccs_pkg::sccs_code_t word_data,
  output logic                      word_take,
  // calibration result
  input  wire logic                 cal_update,
  input  wire logic [63:0]          cal_short,
  // link
  input  wire logic                 link_clk,
  output sccs_pkg::sccs_code_t      sync_word,
  output sccs_pkg::sccs_code_t      data_word,
  // interrupt
  output logic                      irq
);

  // link clock sampling
  logic link_s1_r;
  logic link_s2_r;
  logic link_s3_r;
  logic link_rise;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      link_s3_r <= 1'b0;
    end else begin
      link_s1_r <= link_clk;
      link_s2_r <= link_s1_r;
      link_s3_r <= link_s2_r;
    end
  end

  // one word per link edge; the requester must hold its word until taken
  assign link_rise = link_s2_r & ~link_s3_r;
  assign word_take = link_rise;

  // configuration registers
  sccs_pkg::sccs_low_t  frame_low_r;
  sccs_pkg::sccs_code_t dark_code_r;
  sccs_pkg::sccs_code_t valid_code_r;
  sccs_pkg::sccs_code_t crc_code_r;
  sccs_pkg::sccs_code_t train_code_r;
  sccs_pkg::sccs_code_t train_word_r;
  sccs_pkg::sccs_stat_t stat_r;
  sccs_pkg::sccs_stat_t stat_nxt;
  sccs_pkg::sccs_stat_t mask_r;
  sccs_pkg::sccs_word_t rdata_r;
  logic                 irq_r;

  // write decode
  logic wr_frame;
  logic wr_dark;
  logic wr_valid;
  logic wr_crc;
  logic wr_tcode;
  logic wr_tword;
  logic wr_stat;
  logic wr_mask;

  assign wr_frame = reg_wr && reg_addr == sccs_pkg::A_FRAME_LOW;
  assign wr_dark  = reg_wr && reg_addr == sccs_pkg::A_DARK_CODE;
  assign wr_valid = reg_wr && reg_addr == sccs_pkg::A_VALID_CODE;
  assign wr_crc   = reg_wr && reg_addr == sccs_pkg::A_CRC_CODE;
  assign wr_tcode = reg_wr && reg_addr == sccs_pkg::A_TRAIN_CODE;
  assign wr_tword = reg_wr && reg_addr == sccs_pkg::A_TRAIN_WORD;
  assign wr_stat  = reg_wr && reg_addr == sccs_pkg::A_IRQ_STAT;
  assign wr_mask  = reg_wr && reg_addr == sccs_pkg::A_IRQ_MASK;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_low_r <= sccs_pkg::RST_FRAME_LOW;
    end else if (wr_frame) begin
      frame_low_r <= reg_wdata[sccs_pkg::LOW_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dark_code_r  <= sccs_pkg::RST_DARK_CODE;
      valid_code_r <= sccs_pkg::RST_VALID_CODE;
      crc_code_r   <= sccs_pkg::RST_CRC_CODE;
    end else begin
      if (wr_dark) begin
        dark_code_r <= reg_wdata[sccs_pkg::CODE_W-1:0];
      end
      if (wr_valid) begin
        valid_code_r <= reg_wdata[sccs_pkg::CODE_W-1:0];
      end
      if (wr_crc) begin
        crc_code_r <= reg_wdata[sccs_pkg::CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      train_code_r <= sccs_pkg::RST_TRAIN_CODE;
      train_word_r <= sccs_pkg::RST_TRAIN_WORD;
    end else begin
      if (wr_tcode) begin
        train_code_r <= reg_wdata[sccs_pkg::CODE_W-1:0];
      end
      if (wr_tword) begin
        train_word_r <= reg_wdata[sccs_pkg::CODE_W-1:0];
      end
    end
  end

  // marker decode of the offered word
  logic is_frame;
  logic is_start;
  logic is_end;
  logic is_mark;
  sccs_pkg::sccs_code_t marker;

  assign is_frame = word_kind == sccs_pkg::K_FS ||
                    word_kind == sccs_pkg::K_FE;
  assign is_start = word_kind == sccs_pkg::K_FS ||
                    word_kind == sccs_pkg::K_LS;
  assign is_end   = word_kind == sccs_pkg::K_FE ||
                    word_kind == sccs_pkg::K_LE;
  assign is_mark  = is_frame | is_start | is_end;

  // frame/line, start, end above low bits
  always_comb begin
    marker = {3'h0, frame_low_r};
    marker[sccs_pkg::MK_FRAME_BIT] = is_frame;
    marker[sccs_pkg::MK_START_BIT] = is_start;
    marker[sccs_pkg::MK_END_BIT]   = is_end;
  end

  // code selection for the sync channel
  sccs_pkg::sccs_code_t sync_nxt;
  sccs_pkg::sccs_code_t data_nxt;
  sccs_pkg::sccs_code_t sync_r;
  sccs_pkg::sccs_code_t data_r;

  always_comb begin
    unique case (word_kind)
      sccs_pkg::K_IDLE:  sync_nxt = train_code_r;
      sccs_pkg::K_DARK:  sync_nxt = dark_code_r;
      sccs_pkg::K_VALID: sync_nxt = valid_code_r;
      sccs_pkg::K_CRC:   sync_nxt = crc_code_r;
      default:           sync_nxt = marker;
    endcase
  end

  assign data_nxt = (word_kind == sccs_pkg::K_IDLE) ? train_word_r
                                                     : word_data;

  // idle words until the first link edge after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_r <= sccs_pkg::RST_TRAIN_CODE;
      data_r <= sccs_pkg::RST_TRAIN_WORD;
    end else if (link_rise) begin
      sync_r <= sync_nxt;
      data_r <= data_nxt;
    end
  end

  assign sync_word = sync_r;
  assign data_word = data_r;

  // stream position tracker
  sccs_pkg::sccs_fstate_t fstate_r;
  sccs_pkg::sccs_fstate_t fstate_nxt;

  always_comb begin
    fstate_nxt = fstate_r;
    if (link_rise) begin
      unique case (word_kind)
        sccs_pkg::K_FS: fstate_nxt = sccs_pkg::FS_FRAME;
        sccs_pkg::K_LS: fstate_nxt = sccs_pkg::FS_LINE;
        sccs_pkg::K_LE: fstate_nxt = sccs_pkg::FS_FRAME;
        sccs_pkg::K_FE: fstate_nxt = sccs_pkg::FS_IDLE;
        default:        fstate_nxt = fstate_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fstate_r <= sccs_pkg::FS_IDLE;
    end else begin
      fstate_r <= fstate_nxt;
    end
  end

  // fault flags, one instance per group of channels
  logic [63:0] fault_flags;

  // channel n lands in bit n
  for (genvar g = 0; g < sccs_pkg::GRP_N; g++) begin : g_fault
    sccs_fault_word #(
      .W (sccs_pkg::GRP_W)
    ) u_fault (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .update   (cal_update),
      .short_in (cal_short[g*sccs_pkg::GRP_W +: sccs_pkg::GRP_W]),
      .flags    (fault_flags[g*sccs_pkg::GRP_W +: sccs_pkg::GRP_W])
    );
  end

  // interrupt events
  sccs_pkg::sccs_stat_t ev;
  sccs_pkg::sccs_stat_t clr;

  always_comb begin
    ev = '0;
    ev[sccs_pkg::ST_FAULT]  = cal_update & (|cal_short);
    ev[sccs_pkg::ST_FSTART] = link_rise && word_kind == sccs_pkg::K_FS;
    ev[sccs_pkg::ST_FEND]   = link_rise && word_kind == sccs_pkg::K_FE;
  end

  // a new event beats a clear in the same cycle
  assign clr      = wr_stat ? reg_wdata[sccs_pkg::STAT_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr) | ev;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_r <= sccs_pkg::RST_STAT;
      mask_r <= sccs_pkg::RST_STAT;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= reg_wdata[sccs_pkg::STAT_W-1:0];
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign irq = irq_r;

  // read selection; unmapped addresses read zero
  sccs_pkg::sccs_word_t rd_mux;

  // fault words read back, writes ignored
  assign rd_mux =
  (reg_addr == sccs_pkg::A_TRAIN_WORD) ? sccs_pkg::sccs_word_t'(train_word_r) :
  (reg_addr == sccs_pkg::A_FRAME_LOW)  ? sccs_pkg::sccs_word_t'(frame_low_r) :
  (reg_addr == sccs_pkg::A_DARK_CODE)  ? sccs_pkg::sccs_word_t'(dark_code_r) :
  (reg_addr == sccs_pkg::A_VALID_CODE) ? sccs_pkg::sccs_word_t'(valid_code_r) :
  (reg_addr == sccs_pkg::A_CRC_CODE)   ? sccs_pkg::sccs_word_t'(crc_code_r) :
  (reg_addr == sccs_pkg::A_TRAIN_CODE) ? sccs_pkg::sccs_word_t'(train_code_r) :
  (reg_addr == sccs_pkg::A_FAULT0)     ? fault_flags[15:0] :
  (reg_addr == sccs_pkg::A_FAULT1)     ? fault_flags[31:16] :
  (reg_addr == sccs_pkg::A_FAULT2)     ? fault_flags[47:32] :
  (reg_addr == sccs_pkg::A_FAULT3)     ? fault_flags[63:48] :
  (reg_addr == sccs_pkg::A_SPARE0)     ? sccs_pkg::RST_SPARE0 :
  (reg_addr == sccs_pkg::A_SPARE1)     ? sccs_pkg::RST_SPARE1 :
  (reg_addr == sccs_pkg::A_IRQ_STAT)   ? sccs_pkg::sccs_word_t'(stat_r) :
  (reg_addr == sccs_pkg::A_IRQ_MASK)   ? sccs_pkg::sccs_word_t'(mask_r) :
  (reg_addr == sccs_pkg::A_LINK_STATE) ? sccs_pkg::sccs_word_t'(fstate_r) :
  '0;

  // read data only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_r;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_frame_low_bits: assert property (
    link_rise && is_mark |=> sync_word[6:0] == $past(frame_low_r))
    else $error("marker low bits differ from frame register");

  a_frame_rd_top: assert property (
    reg_rd && reg_addr == sccs_pkg::A_FRAME_LOW
      |=> reg_rdata[15:7] == '0 && reg_rdata[6:0] == frame_low_r)
    else $error("frame marker register reads wrong");

  a_marker_top_bits: assert property (
    link_rise && word_kind == sccs_pkg::K_LE
      ##1 1'b1 |-> sync_word[9:7] == 3'b001)
    else $error("line end marker top bits wrong");

  a_frame_start_bits: assert property (
    link_rise && word_kind == sccs_pkg::K_FS |=> sync_word[9:7] == 3'b110)
    else $error("frame start marker top bits wrong");

  a_dark_code_out: assert property (
    link_rise && word_kind == sccs_pkg::K_DARK
      |=> sync_word == $past(dark_code_r) && data_word == $past(word_data))
    else $error("dark pixel marker wrong");

  a_valid_code_out: assert property (
    link_rise && word_kind == sccs_pkg::K_VALID
      |=> sync_word == $past(valid_code_r))
    else $error("valid pixel marker wrong");

  a_crc_code_out: assert property (
    link_rise && word_kind == sccs_pkg::K_CRC
      |=> sync_word == $past(crc_code_r))
    else $error("checksum marker wrong");

  a_fault_capture: assert property (
    cal_update |=> fault_flags == $past(cal_short))
    else $error("fault flags missed calibration result");

  a_fault_hold: assert property (
    !cal_update |=> $stable(fault_flags))
    else $error("fault flags changed without calibration");

  a_fault_read_hi: assert property (
    reg_rd && reg_addr == sccs_pkg::A_FAULT3
      |=> reg_rdata == $past(fault_flags[63:48]))
    else $error("channels 48-63 read back wrong");

  a_idle_training: assert property (
    link_rise && word_kind == sccs_pkg::K_IDLE
      |=> data_word == $past(train_word_r))
    else $error("idle data word is not the training word");

  a_train_marker: assert property (
    link_rise && word_kind == sccs_pkg::K_IDLE
      |=> sync_word == $past(train_code_r))
    else $error("training marker wrong");

  a_words_stable: assert property (
    !link_rise |=> $stable(sync_word) && $stable(data_word))
    else $error("link words moved between link edges");

  c_frame_start: cover property (link_rise && word_kind == sccs_pkg::K_FS);
  c_dark_word: cover property (link_rise && word_kind == sccs_pkg::K_DARK);
  c_fault_seen: cover property (cal_update && (|cal_short));
  c_irq_rise: cover property ($rose(irq));

endmodule : sccs_framer

// file: test/sccs_rx_model.sv
// receiver-side model: link clock source and word capture
`timescale 1ns/100ps
module sccs_rx_model (
  // control
  input  wire logic                 run,
  // link
  input  wire sccs_pkg::sccs_code_t sync_word,
  input  wire sccs_pkg::sccs_code_t data_word,
  output logic                      link_clk,
  // decoded words
  output logic                      rx_frame,
  output logic                      rx_start,
  output logic                      rx_end,
  output sccs_pkg::sccs_code_t      rx_data
);
  initial link_clk = 1'b0;

  // clock stands still between bursts
  always begin
    if (!run) begin
      link_clk = 1'b0;
      wait (run);
      // odd offset keeps phase unrelated to the system clock
      #7;
    end
    #160 link_clk = 1'b1;
    #160 link_clk = 1'b0;
  end

  always @(posedge link_clk) begin
    rx_frame <= sync_word[9];
    rx_start <= sync_word[8];
    rx_end   <= sync_word[7];
    rx_data  <= data_word;
  end
endmodule : sccs_rx_model

// file: test/sccs_framer_tb.sv
// self-checking bench for the sync code framer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module sccs_framer_tb;
  logic                 clock      = 1'b0;
  logic                 sys_rst    = 1'b1;
  sccs_pkg::sccs_addr_t reg_addr   = 8'h00;
  sccs_pkg::sccs_word_t reg_wdata  = 16'h0000;
  logic                 reg_wr     = 1'b0;
  logic                 reg_rd     = 1'b0;
  sccs_pkg::sccs_word_t reg_rdata;
  sccs_pkg::sccs_kind_t word_kind  = sccs_pkg::K_IDLE;
  sccs_pkg::sccs_code_t word_data  = 10'h000;
  logic                 word_take;
  logic                 cal_update = 1'b0;
  logic [63:0]          cal_short  = 64'h0;
  logic                 link_clk;
  sccs_pkg::sccs_code_t sync_word;
  sccs_pkg::sccs_code_t data_word;
  logic                 irq;
  logic                 run        = 1'b0;
  int                   error_cnt  = 0;
  int                   n_compared = 0;
  logic                 rx_frame;
  logic                 rx_start;
  logic                 rx_end;
  sccs_pkg::sccs_code_t rx_data;
  // word the receiver should latch at the coming link edge
  sccs_pkg::sccs_code_t prev_s     = 10'h3a6;
  sccs_pkg::sccs_code_t prev_d     = 10'h3a6;

  always #20 clock = ~clock;

  sccs_framer dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .word_kind(word_kind), .word_data(word_data),
    .word_take(word_take), .cal_update(cal_update), .cal_short(cal_short),
    .link_clk(link_clk), .sync_word(sync_word), .data_word(data_word),
    .irq(irq));

  sccs_rx_model rx (.run(run), .sync_word(sync_word), .data_word(data_word),
    .link_clk(link_clk), .rx_frame(rx_frame), .rx_start(rx_start),
    .rx_end(rx_end), .rx_data(rx_data));

  function automatic sccs_pkg::sccs_word_t rst_val(input int a);
    case (a)
      8'h82, 8'h87: return 16'h03a6;
      8'h83:        return 16'h002a;
      8'h84:        return 16'h0015;
      8'h85:        return 16'h0035;
      8'h86:        return 16'h0059;
      8'h8d:        return 16'hffff;
      default:      return 16'h0000;
    endcase
  endfunction : rst_val

  task automatic reg_write(input sccs_pkg::sccs_addr_t a,
                           input sccs_pkg::sccs_word_t d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input sccs_pkg::sccs_addr_t a,
                           input sccs_pkg::sccs_word_t e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : reg_check

  task automatic send_word(input int k, input sccs_pkg::sccs_code_t d,
                           input sccs_pkg::sccs_code_t es,
                           input sccs_pkg::sccs_code_t ed);
    int i;
    @(posedge clock);
    word_kind <= sccs_pkg::sccs_kind_t'(k[2:0]);
    word_data <= d;
    // bounded wait for the link edge to be taken
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      if (word_take === 1'b1) break;
    end
    `CHK("word_take", 1'b1, word_take)
    `CHK("rx_frame", prev_s[9], rx_frame)
    `CHK("rx_start", prev_s[8], rx_start)
    `CHK("rx_end", prev_s[7], rx_end)
    `CHK("rx_data", prev_d, rx_data)
    @(posedge clock);
    #1;
    `CHK("sync_word", es, sync_word)
    `CHK("data_word", ed, data_word)
    prev_s = es;
    prev_d = ed;
  endtask : send_word

  task automatic t_reset;
    int a;
    `CHK("sync_word", 10'h3a6, sync_word)
    `CHK("data_word", 10'h3a6, data_word)
    `CHK("irq", 1'b0, irq)
    // unmapped neighbours included
    for (a = 8'h80; a <= 8'h91; a++)
      reg_check(8'(a), rst_val(a));
    $display("test reset values done");
  endtask : t_reset

  task automatic t_write;
    int a;
    for (a = 0; a < 6; a++)
      reg_write(8'(8'h82 + a), 16'(16'h0111 * (a + 1)));
    // read-only, spare, state and unmapped places keep their value
    for (a = 8'h88; a <= 8'h91; a++)
      if (a != 8'h8e && a != 8'h8f) reg_write(8'(a), 16'h1234);
    reg_write(8'h80, 16'h1234);
    for (a = 0; a < 6; a++)
      reg_check(8'(8'h82 + a), 16'(16'h0111 * (a + 1)) &
                (a == 1 ? 16'h007f : 16'h03ff));
    for (a = 8'h88; a <= 8'h91; a++)
      if (a != 8'h8e && a != 8'h8f) reg_check(8'(a), rst_val(a));
    reg_check(8'h80, 16'h0000);
    $display("test register writes done");
  endtask : t_write

  task automatic t_link;
    sccs_pkg::sccs_code_t es [8] = '{10'h266, 10'h322, 10'h2a2, 10'h122,
                                     10'h0a2, 10'h333, 10'h044, 10'h155};
    int k;
    run <= 1'b1;
    for (k = 0; k < 8; k++) begin
      send_word(k, 10'(10'h0a0 + k), es[k],
                k == 0 ? 10'h111 : 10'(10'h0a0 + k));
      // stream sits inside a line after the line start word
      if (k == 3) reg_check(8'h90, 16'h0003);
    end
    // back to idle after the checksum word
    send_word(0, 10'h3ff, 10'h266, 10'h111);
    run <= 1'b0;
    $display("test link words done");
  endtask : t_link

  task automatic t_cal;
    @(posedge clock);
    cal_update <= 1'b1;
    cal_short  <= 64'h8001_0004_0020_1003;
    @(posedge clock);
    cal_update <= 1'b0;
    cal_short  <= 64'h0;
    reg_check(8'h88, 16'h1003);
    reg_check(8'h89, 16'h0020);
    reg_check(8'h8a, 16'h0004);
    reg_check(8'h8b, 16'h8001);
    // fault plus frame start and end seen
    reg_check(8'h8e, 16'h0007);
    `CHK("irq", 1'b0, irq)
    reg_write(8'h8f, 16'h0001);
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq", 1'b1, irq)
    reg_write(8'h8e, 16'h0007);
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq", 1'b0, irq)
    reg_check(8'h8e, 16'h0000);
    // flags replaced wholesale on the next result
    @(posedge clock);
    cal_update <= 1'b1;
    @(posedge clock);
    cal_update <= 1'b0;
    reg_check(8'h8b, 16'h0000);
    $display("test calibration faults done");
  endtask : t_cal

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_write();
    t_link();
    t_cal();
    give_verdict();
  end
endmodule : sccs_framer_tb
